/* File: hdl/batc_pkg.sv */
// Constants, field layouts and carrier types for the buffer area and transfer counter bank.
// Assumes an 8-bit register port and a single system clock domain.
// What this block does
// - Pack grouping high: group four packs starting five packs before subcode sync.
// - Pack grouping low: group the four packs just before subcode sync.
// - Software loads start area; area pointer increments when a sector finishes buffering.
// - Subcode buffering command ignores area pointer and starts at buffer address zero.
// - Read-only 9-bit current sector area shows the area being written.
// - Last-area stop enabled and last area written: inhibit further buffering.
// - Target address mismatch with current sector sets target mismatch flag bit 0.
// - Software loads 24-bit block count; device decrements it per completed block.
// - Automatic transfer starts at send area and increments it per block.
// - Block position increments per block in 512 and 1024 modes; upper bit ignored in 1024 mode.
// - Transfer area, position, block counts readable any time, may be off by one.
// - Manual mode uses 20-bit byte count; remaining count readable there.
// - Manual mode transfer begins at the programmed 20-bit head address.
package batc_pkg;
    localparam logic [7:0] ADDR_CHIP_CTL1 = 8'h15;
    localparam logic [7:0] ADDR_BFAREA_H = 8'h20;
    localparam logic [7:0] ADDR_BFAREA_L = 8'h21;
    localparam logic [7:0] ADDR_CURAREA_H = 8'h22;
    localparam logic [7:0] ADDR_CURAREA_L = 8'h23;
    localparam logic [7:0] ADDR_LAST_H = 8'h24;
    localparam logic [7:0] ADDR_LAST_L = 8'h25;
    localparam logic [7:0] ADDR_TGT_MIN = 8'h27;
    localparam logic [7:0] ADDR_TGT_SEC = 8'h28;
    localparam logic [7:0] ADDR_TGT_FRM = 8'h29;
    localparam logic [7:0] ADDR_REMBLK_H = 8'h2b;
    localparam logic [7:0] ADDR_REMBLK_M = 8'h2c;
    localparam logic [7:0] ADDR_REMBLK_L = 8'h2d;
    localparam logic [7:0] ADDR_SENDAREA_H = 8'h2e;
    localparam logic [7:0] ADDR_SENDAREA_L = 8'h2f;
    localparam logic [7:0] ADDR_POS = 8'h31;
    localparam logic [7:0] ADDR_MBC_H = 8'h33;
    localparam logic [7:0] ADDR_MBC_M = 8'h34;
    localparam logic [7:0] ADDR_MBC_L = 8'h35;
    localparam logic [7:0] ADDR_MHA_H = 8'h37;
    localparam logic [7:0] ADDR_MHA_M = 8'h38;
    localparam logic [7:0] ADDR_MHA_L = 8'h39;
    // Registers of our own: decoder control/status and interrupt pair
    localparam logic [7:0] ADDR_DEC_CTL0 = 8'h60;
    localparam logic [7:0] ADDR_DEC_STS0 = 8'h61;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h62;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h63;
    // Field positions
    localparam int PACK_SEL_BIT = 2;
    localparam int LAST_STOP_BIT = 1;
    localparam int MISMATCH_BIT = 0;
    // Interrupt status bits
    localparam int IRQ_SECTOR = 0;
    localparam int IRQ_BLOCK = 1;
    localparam int IRQ_STOP = 2;
    localparam int IRQ_MISMATCH = 3;
    localparam int IRQ_BITS = 4;
    // Pack grouping: offset of first pack before sync
    localparam logic [2:0] PACK_OFS_HIGH = 3'h5;
    localparam logic [2:0] PACK_OFS_LOW = 3'h4;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Transfer modes and buffering commands
    typedef enum logic [3:0] {
        BATC_CMD_IDLE = 4'b0001,
        BATC_CMD_AREA = 4'b0010,
        BATC_CMD_SUBC = 4'b0100,
        BATC_CMD_MON = 4'b1000
    } batc_cmd_e;
    typedef enum logic [1:0] {
        BATC_XM_OTHER = 2'h0,
        BATC_XM_512 = 2'h1,
        BATC_XM_1024 = 2'h2,
        BATC_XM_MANUAL = 2'h3
    } batc_xmode_e;

    // Sector events from the decoder core
    typedef struct packed {
        logic sector_start;
        logic sector_done;
        logic [23:0] cur_addr;
    } batc_sector_s;
    // Transfer events from the host transfer engine
    typedef struct packed {
        logic block_done;
        logic byte_done;
        batc_xmode_e xmode;
    } batc_xfer_s;
endpackage

/* File: hdl/batc_regs.sv */
// Buffer area and transfer counter register bank of the disc data decoder.
// Assumes sector and transfer events are pulses from logic on mclk.
module batc_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Decoder side
    input wire batc_pkg::batc_cmd_e cmd,
    input wire batc_pkg::batc_sector_s sector,
    input wire batc_pkg::batc_xfer_s xfer,
    output logic buffering_inhibit,
    output logic [8:0] buffering_area,
    output logic [19:0] buffer_write_addr,
    output logic [2:0] pack_group_offset,
    // Transfer engine side
    output logic [8:0] send_area,
    output logic [1:0] first_block_position,
    output logic [23:0] remaining_blocks,
    output logic [19:0] manual_byte_count,
    output logic [19:0] manual_head_addr,
    // Interrupt
    output logic irq
);
    import batc_pkg::*;

    logic rst_meta;
    logic rst_sync_n;
    logic [7:0] chip_control_one, next_chip_control_one;
    logic [7:0] decoder_control_zero, next_decoder_control_zero;
    logic [8:0] next_buffering_area;
    logic [8:0] current_sector_area, next_current_sector_area;
    logic [8:0] drive_last_area, next_drive_last_area;
    logic [7:0] target_minutes, next_target_minutes;
    logic [7:0] target_seconds, next_target_seconds;
    logic [7:0] target_frames, next_target_frames;
    logic target_mismatch_flag, next_target_mismatch_flag;
    logic next_buffering_inhibit;
    logic [19:0] next_buffer_write_addr;
    logic [23:0] next_remaining_blocks;
    logic [8:0] next_send_area;
    logic [1:0] next_first_block_position;
    logic [19:0] next_manual_byte_count;
    logic [19:0] next_manual_head_addr;
    logic [IRQ_BITS-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, irq_event;
    logic [7:0] next_reg_rdata;
    logic next_irq;
    logic [2:0] next_pack_group_offset;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    // Reset release through two flops keeps deassertion glitch free
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    logic wr_bfh, wr_bfl, wr_rbh, wr_rbm, wr_rbl, wr_sah, wr_sal, wr_pos;
    logic wr_mbh, wr_mbm, wr_mbl, wr_mhh, wr_mhm, wr_mhl;
    assign wr_bfh = reg_wr && hit(reg_addr, ADDR_BFAREA_H);
    assign wr_bfl = reg_wr && hit(reg_addr, ADDR_BFAREA_L);
    assign wr_rbh = reg_wr && hit(reg_addr, ADDR_REMBLK_H);
    assign wr_rbm = reg_wr && hit(reg_addr, ADDR_REMBLK_M);
    assign wr_rbl = reg_wr && hit(reg_addr, ADDR_REMBLK_L);
    assign wr_sah = reg_wr && hit(reg_addr, ADDR_SENDAREA_H);
    assign wr_sal = reg_wr && hit(reg_addr, ADDR_SENDAREA_L);
    assign wr_pos = reg_wr && hit(reg_addr, ADDR_POS);
    assign wr_mbh = reg_wr && hit(reg_addr, ADDR_MBC_H);
    assign wr_mbm = reg_wr && hit(reg_addr, ADDR_MBC_M);
    assign wr_mbl = reg_wr && hit(reg_addr, ADDR_MBC_L);
    assign wr_mhh = reg_wr && hit(reg_addr, ADDR_MHA_H);
    assign wr_mhm = reg_wr && hit(reg_addr, ADDR_MHA_M);
    assign wr_mhl = reg_wr && hit(reg_addr, ADDR_MHA_L);

    logic last_hit;
    logic is_area_cmd;
    logic mismatch_now;
    assign is_area_cmd = (cmd == BATC_CMD_AREA) || (cmd == BATC_CMD_SUBC);
    // Stop when a sector of the programmed last area has been written
    assign last_hit = decoder_control_zero[LAST_STOP_BIT] && is_area_cmd &&
        sector.sector_done && (current_sector_area == drive_last_area);
    assign mismatch_now = sector.sector_start && (cmd != BATC_CMD_IDLE) &&
        (sector.cur_addr != {target_minutes, target_seconds, target_frames});

    // Buffering side next-state: pointer, current area, stop, compare
    always_comb begin
        next_chip_control_one = chip_control_one;
        next_decoder_control_zero = decoder_control_zero;
        next_drive_last_area = drive_last_area;
        next_target_minutes = target_minutes;
        next_target_seconds = target_seconds;
        next_target_frames = target_frames;
        next_buffering_area = buffering_area;
        next_current_sector_area = current_sector_area;
        next_buffer_write_addr = buffer_write_addr;
        next_buffering_inhibit = buffering_inhibit;
        next_target_mismatch_flag = target_mismatch_flag;
        if (cmd == BATC_CMD_IDLE) begin
            next_buffering_inhibit = 1'b0;
            next_buffer_write_addr = 20'h00000;
        end
        if (sector.sector_start && cmd == BATC_CMD_AREA) begin
            next_current_sector_area = buffering_area;
        end
        if (sector.sector_start && cmd == BATC_CMD_SUBC && buffer_write_addr == 20'h00000) begin
            next_current_sector_area = 9'h000;
        end
        if (sector.sector_done && !buffering_inhibit) begin
            if (cmd == BATC_CMD_AREA) begin
                next_buffering_area = buffering_area + 9'h001;
            end
            if (cmd == BATC_CMD_SUBC) begin
                next_buffer_write_addr = buffer_write_addr + 20'h00001;
                next_current_sector_area = current_sector_area + 9'h001;
            end
        end
        if (last_hit) begin
            next_buffering_inhibit = 1'b1;
        end
        if (mismatch_now) begin
            next_target_mismatch_flag = 1'b1;
        end else if (sector.sector_start) begin
            next_target_mismatch_flag = 1'b0;
        end
        // Software writes come last so they win
        if (reg_wr) begin
            if (hit(reg_addr, ADDR_CHIP_CTL1)) begin
                next_chip_control_one = reg_wdata;
            end else if (hit(reg_addr, ADDR_DEC_CTL0)) begin
                next_decoder_control_zero = reg_wdata;
            end else if (hit(reg_addr, ADDR_LAST_H)) begin
                next_drive_last_area[8] = reg_wdata[0];
            end else if (hit(reg_addr, ADDR_LAST_L)) begin
                next_drive_last_area[7:0] = reg_wdata;
            end else if (hit(reg_addr, ADDR_TGT_MIN)) begin
                next_target_minutes = reg_wdata;
            end else if (hit(reg_addr, ADDR_TGT_SEC)) begin
                next_target_seconds = reg_wdata;
            end else if (hit(reg_addr, ADDR_TGT_FRM)) begin
                next_target_frames = reg_wdata;
            end
        end
        if (wr_bfh) begin
            next_buffering_area[8] = reg_wdata[0];
        end
        if (wr_bfl) begin
            next_buffering_area[7:0] = reg_wdata;
        end
        // Offset tracks the control bit as written, so it moves with the register
        next_pack_group_offset = next_chip_control_one[PACK_SEL_BIT] ?
            PACK_OFS_HIGH : PACK_OFS_LOW;
    end

    // Transfer side next-state: block count, area, position, manual counters
    always_comb begin
        next_remaining_blocks = remaining_blocks;
        next_send_area = send_area;
        next_first_block_position = first_block_position;
        next_manual_byte_count = manual_byte_count;
        next_manual_head_addr = manual_head_addr;
        if (xfer.block_done && xfer.xmode != BATC_XM_MANUAL) begin
            next_remaining_blocks = remaining_blocks - 24'h000001;
            next_send_area = send_area + 9'h001;
            if (xfer.xmode == BATC_XM_512) begin
                next_first_block_position = first_block_position + 2'h1;
            end else if (xfer.xmode == BATC_XM_1024) begin
                next_first_block_position[0] = ~first_block_position[0];
            end
        end
        if (xfer.byte_done && xfer.xmode == BATC_XM_MANUAL) begin
            next_manual_byte_count = manual_byte_count - 20'h00001;
            next_manual_head_addr = manual_head_addr + 20'h00001;
        end
        // A write in the same cycle overrides the device update
        if (wr_rbh) next_remaining_blocks[23:16] = reg_wdata;
        if (wr_rbm) next_remaining_blocks[15:8] = reg_wdata;
        if (wr_rbl) next_remaining_blocks[7:0] = reg_wdata;
        if (wr_sah) next_send_area[8] = reg_wdata[0];
        if (wr_sal) next_send_area[7:0] = reg_wdata;
        if (wr_pos) next_first_block_position = reg_wdata[1:0];
        if (wr_mbh) next_manual_byte_count[19:16] = reg_wdata[3:0];
        if (wr_mbm) next_manual_byte_count[15:8] = reg_wdata;
        if (wr_mbl) next_manual_byte_count[7:0] = reg_wdata;
        if (wr_mhh) next_manual_head_addr[19:16] = reg_wdata[3:0];
        if (wr_mhm) next_manual_head_addr[15:8] = reg_wdata;
        if (wr_mhl) next_manual_head_addr[7:0] = reg_wdata;
    end

    // Interrupt: set wins over write-one-to-clear
    always_comb begin
        irq_event = '0;
        irq_event[IRQ_SECTOR] = sector.sector_done;
        irq_event[IRQ_BLOCK] = xfer.block_done;
        irq_event[IRQ_STOP] = last_hit;
        irq_event[IRQ_MISMATCH] = mismatch_now;
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (reg_wr && hit(reg_addr, ADDR_IRQ_STAT)) begin
            next_irq_stat = irq_stat & ~reg_wdata[IRQ_BITS-1:0];
        end
        if (reg_wr && hit(reg_addr, ADDR_IRQ_MASK)) begin
            next_irq_mask = reg_wdata[IRQ_BITS-1:0];
        end
        next_irq_stat = next_irq_stat | irq_event;
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    // Read mux; counters read live, so a read may trail an update by one
    always_comb begin
        next_reg_rdata = RESET_BYTE;
        if (reg_rd) begin
            if (hit(reg_addr, ADDR_CHIP_CTL1)) next_reg_rdata = chip_control_one;
            else if (hit(reg_addr, ADDR_DEC_CTL0)) next_reg_rdata = decoder_control_zero;
            else if (hit(reg_addr, ADDR_DEC_STS0)) next_reg_rdata = {7'h00, target_mismatch_flag};
            else if (hit(reg_addr, ADDR_BFAREA_H)) next_reg_rdata = {7'h00, buffering_area[8]};
            else if (hit(reg_addr, ADDR_BFAREA_L)) next_reg_rdata = buffering_area[7:0];
            else if (hit(reg_addr, ADDR_CURAREA_H)) next_reg_rdata = {7'h00, current_sector_area[8]};
            else if (hit(reg_addr, ADDR_CURAREA_L)) next_reg_rdata = current_sector_area[7:0];
            else if (hit(reg_addr, ADDR_LAST_H)) next_reg_rdata = {7'h00, drive_last_area[8]};
            else if (hit(reg_addr, ADDR_LAST_L)) next_reg_rdata = drive_last_area[7:0];
            else if (hit(reg_addr, ADDR_TGT_MIN)) next_reg_rdata = target_minutes;
            else if (hit(reg_addr, ADDR_TGT_SEC)) next_reg_rdata = target_seconds;
            else if (hit(reg_addr, ADDR_TGT_FRM)) next_reg_rdata = target_frames;
            else if (hit(reg_addr, ADDR_REMBLK_H)) next_reg_rdata = remaining_blocks[23:16];
            else if (hit(reg_addr, ADDR_REMBLK_M)) next_reg_rdata = remaining_blocks[15:8];
            else if (hit(reg_addr, ADDR_REMBLK_L)) next_reg_rdata = remaining_blocks[7:0];
            else if (hit(reg_addr, ADDR_SENDAREA_H)) next_reg_rdata = {7'h00, send_area[8]};
            else if (hit(reg_addr, ADDR_SENDAREA_L)) next_reg_rdata = send_area[7:0];
            else if (hit(reg_addr, ADDR_POS)) next_reg_rdata = {6'h00, first_block_position};
            else if (hit(reg_addr, ADDR_MBC_H)) next_reg_rdata = {4'h0, manual_byte_count[19:16]};
            else if (hit(reg_addr, ADDR_MBC_M)) next_reg_rdata = manual_byte_count[15:8];
            else if (hit(reg_addr, ADDR_MBC_L)) next_reg_rdata = manual_byte_count[7:0];
            else if (hit(reg_addr, ADDR_MHA_H)) next_reg_rdata = {4'h0, manual_head_addr[19:16]};
            else if (hit(reg_addr, ADDR_MHA_M)) next_reg_rdata = manual_head_addr[15:8];
            else if (hit(reg_addr, ADDR_MHA_L)) next_reg_rdata = manual_head_addr[7:0];
            else if (hit(reg_addr, ADDR_IRQ_STAT)) next_reg_rdata = {4'h0, irq_stat};
            else if (hit(reg_addr, ADDR_IRQ_MASK)) next_reg_rdata = {4'h0, irq_mask};
        end
    end

    // All state registers except the two reset synchronizer flops
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chip_control_one <= RESET_BYTE;
            decoder_control_zero <= RESET_BYTE;
            buffering_area <= 9'h000;
            current_sector_area <= 9'h000;
            drive_last_area <= 9'h000;
            target_minutes <= RESET_BYTE;
            target_seconds <= RESET_BYTE;
            target_frames <= RESET_BYTE;
            target_mismatch_flag <= 1'b0;
            buffering_inhibit <= 1'b0;
            buffer_write_addr <= 20'h00000;
            remaining_blocks <= 24'h000000;
            send_area <= 9'h000;
            first_block_position <= 2'h0;
            manual_byte_count <= 20'h00000;
            manual_head_addr <= 20'h00000;
            irq_stat <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
            reg_rdata <= RESET_BYTE;
            pack_group_offset <= PACK_OFS_LOW;
        end else begin
            chip_control_one <= next_chip_control_one;
            decoder_control_zero <= next_decoder_control_zero;
            buffering_area <= next_buffering_area;
            current_sector_area <= next_current_sector_area;
            drive_last_area <= next_drive_last_area;
            target_minutes <= next_target_minutes;
            target_seconds <= next_target_seconds;
            target_frames <= next_target_frames;
            target_mismatch_flag <= next_target_mismatch_flag;
            buffering_inhibit <= next_buffering_inhibit;
            buffer_write_addr <= next_buffer_write_addr;
            remaining_blocks <= next_remaining_blocks;
            send_area <= next_send_area;
            first_block_position <= next_first_block_position;
            manual_byte_count <= next_manual_byte_count;
            manual_head_addr <= next_manual_head_addr;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq <= next_irq;
            reg_rdata <= next_reg_rdata;
            pack_group_offset <= next_pack_group_offset;
        end
    end

    // Checks on pointer, counter and flag stepping
    a_area_step: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        sector.sector_done && cmd == BATC_CMD_AREA && !buffering_inhibit && !wr_bfh && !wr_bfl
        |=> buffering_area == $past(buffering_area) + 9'h001)
        else $error("buffering area did not step");
    a_stop_hold: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        last_hit |=> buffering_inhibit)
        else $error("last area did not inhibit buffering");
    a_mismatch_set: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        mismatch_now |=> target_mismatch_flag ##0 irq_stat[IRQ_MISMATCH])
        else $error("mismatch flag not set");
    a_blocks_dec: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        xfer.block_done && xfer.xmode != BATC_XM_MANUAL && !wr_rbh && !wr_rbm && !wr_rbl
        |=> remaining_blocks == $past(remaining_blocks) - 24'h000001)
        else $error("block count not decremented");
    a_send_area: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        xfer.block_done && xfer.xmode != BATC_XM_MANUAL && !wr_sah && !wr_sal
        |=> send_area == $past(send_area) + 9'h001)
        else $error("send area not incremented");
    a_pos_1024: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        xfer.block_done && xfer.xmode == BATC_XM_1024 && !wr_pos
        |=> first_block_position[1] == $past(first_block_position[1]))
        else $error("upper position bit moved in 1024 mode");
    a_other_pos: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        xfer.block_done && xfer.xmode == BATC_XM_OTHER && !wr_pos
        |=> first_block_position == $past(first_block_position))
        else $error("position moved outside 512 and 1024 modes");
    a_manual_count: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        xfer.byte_done && xfer.xmode == BATC_XM_MANUAL && !wr_mbh && !wr_mbm && !wr_mbl
        |=> manual_byte_count == $past(manual_byte_count) - 20'h00001)
        else $error("manual byte count not decremented");
    a_cur_area: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        sector.sector_start && cmd == BATC_CMD_AREA
        |=> current_sector_area == $past(buffering_area))
        else $error("current area not loaded from pointer");
    a_subc_zero: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        sector.sector_start && cmd == BATC_CMD_SUBC && buffer_write_addr == 20'h00000
        |=> current_sector_area == 9'h000)
        else $error("subcode buffering did not start at zero");
    a_write_wins: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        wr_rbl && xfer.block_done |=> remaining_blocks[7:0] == $past(reg_wdata))
        else $error("device update beat software write");
    a_pack_sel: assert property (@(posedge mclk) disable iff (!rst_sync_n)
        chip_control_one[PACK_SEL_BIT] |-> pack_group_offset == PACK_OFS_HIGH)
        else $error("pack grouping offset wrong");
endmodule

/* File: test/batc_core_model.sv */
// Behavioural decoder core and transfer engine feeding the register bank.
// Assumes the bench calls its tasks; events are one-cycle pulses after mclk.
module batc_core_model
    import batc_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Events
    output batc_pkg::batc_sector_s sector,
    output batc_pkg::batc_xfer_s xfer
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sector = '0;
        xfer = '0;
    end
    // Start pulse, then done pulse; address always legal BCD
    task automatic run_sector(input logic [23:0] bcd);
        @(posedge mclk);
        sector <= '{1'b1, 1'b0, bcd};
        @(posedge mclk);
        sector <= '{1'b0, 1'b1, bcd};
        @(posedge mclk);
        sector <= '{1'b0, 1'b0, bcd};
    endtask
    // One finished block in the given mode
    task automatic run_block(input batc_xmode_e m);
        @(posedge mclk);
        xfer <= '{1'b1, 1'b0, m};
        @(posedge mclk);
        xfer <= '{1'b0, 1'b0, m};
    endtask
    // One byte moved in manual mode
    task automatic run_byte();
        @(posedge mclk);
        xfer <= '{1'b0, 1'b1, BATC_XM_MANUAL};
        @(posedge mclk);
        xfer <= '{1'b0, 1'b0, BATC_XM_MANUAL};
    endtask
endmodule

/* File: test/testbench.sv */
// Self-checking bench for the buffer area and transfer counter bank.
// Assumes the core model supplies sector and block events.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import batc_pkg::*;
    logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, d;
    batc_cmd_e cmd = BATC_CMD_IDLE;
    batc_sector_s sector;
    batc_xfer_s xfer;
    logic buffering_inhibit;
    logic [8:0] buffering_area, send_area;
    logic [19:0] buffer_write_addr, manual_byte_count, manual_head_addr;
    logic [2:0] pack_group_offset;
    logic [1:0] first_block_position;
    logic [23:0] remaining_blocks;
    int n_errors = 0, tests_run = 0;
    always #20 mclk = ~mclk;
    batc_core_model i_core (.mclk(mclk), .sector(sector), .xfer(xfer));
    batc_regs i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd(cmd), .sector(sector),
        .xfer(xfer), .buffering_inhibit(buffering_inhibit), .buffering_area(buffering_area),
        .buffer_write_addr(buffer_write_addr), .pack_group_offset(pack_group_offset),
        .send_area(send_area), .first_block_position(first_block_position),
        .remaining_blocks(remaining_blocks), .manual_byte_count(manual_byte_count),
        .manual_head_addr(manual_head_addr), .irq(irq));
    // Bus cycles: one strobe cycle, then a gap; high bytes keep upper bits zero
    // Returns just after the edge so the written value has settled
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Pack offset, manual counters (odd head, count not three) unmapped place
    task automatic s_regs();
        chk("pack_low", 24'h4, 24'(pack_group_offset));
        wr(ADDR_CHIP_CTL1, 8'h04);
        chk("pack_high", 24'h5, 24'(pack_group_offset));
        wr(ADDR_MBC_H, 8'h0f); wr(ADDR_MBC_M, 8'hab); wr(ADDR_MBC_L, 8'hcd);
        chk("byte_count", 24'hfabcd, 24'(manual_byte_count));
        rd(ADDR_MBC_L); chk("byte_count_rd", 24'hcd, 24'(d));
        wr(ADDR_MHA_H, 8'h01); wr(ADDR_MHA_M, 8'h23); wr(ADDR_MHA_L, 8'h45);
        chk("head_addr", 24'h12345, 24'(manual_head_addr));
        i_core.run_byte();
        #1 chk("byte_count_dec", 24'hfabcc, 24'(manual_byte_count));
        chk("head_addr_inc", 24'h12346, 24'(manual_head_addr));
        rd(8'h7f); chk("unmapped", 24'h0, 24'(d));
    endtask
    // Area pointer wraps at nine bits; current area and last-area stop
    task automatic s_area();
        cmd <= BATC_CMD_AREA;
        wr(ADDR_BFAREA_H, 8'h01); wr(ADDR_BFAREA_L, 8'hff);
        wr(ADDR_DEC_CTL0, 8'h02); wr(ADDR_LAST_H, 8'h01); wr(ADDR_LAST_L, 8'hff);
        wr(ADDR_IRQ_MASK, 8'h04);
        i_core.run_sector(24'h000000);
        @(posedge mclk); #1;
        chk("area_wrap", 24'h0, 24'(buffering_area));
        chk("inhibit", 24'h1, 24'(buffering_inhibit));
        chk("irq_stop", 24'h1, 24'(irq));
        wr(ADDR_CURAREA_L, 8'h00);
        rd(ADDR_CURAREA_L); chk("cur_low", 24'hff, 24'(d));
        rd(ADDR_CURAREA_H); chk("cur_high", 24'h1, 24'(d));
        wr(ADDR_IRQ_STAT, 8'hff);
        #1 chk("irq_clear", 24'h0, 24'(irq));
        cmd <= BATC_CMD_IDLE;
        @(posedge mclk); @(posedge mclk); #1;
        chk("inhibit_off", 24'h0, 24'(buffering_inhibit));
    endtask
    // Target compare against a sector one frame away
    task automatic s_target();
        wr(ADDR_TGT_MIN, 8'h12); wr(ADDR_TGT_SEC, 8'h34); wr(ADDR_TGT_FRM, 8'h56);
        cmd <= BATC_CMD_MON;
        i_core.run_sector(24'h123457);
        rd(ADDR_DEC_STS0); chk("mismatch", 24'h1, 24'(d[MISMATCH_BIT]));
        wr(ADDR_BFAREA_L, 8'h55);
        cmd <= BATC_CMD_SUBC;
        i_core.run_sector(24'h123456);
        rd(ADDR_DEC_STS0); chk("match", 24'h0, 24'(d[MISMATCH_BIT]));
        chk("subc_addr", 24'h1, 24'(buffer_write_addr));
        chk("subc_area", 24'h55, 24'(buffering_area));
        cmd <= BATC_CMD_IDLE;
    endtask
    // Block counter, send area and position across a carry and a wrap
    task automatic s_blocks();
        wr(ADDR_REMBLK_H, 8'h00); wr(ADDR_REMBLK_M, 8'h01); wr(ADDR_REMBLK_L, 8'h00);
        wr(ADDR_SENDAREA_H, 8'h00); wr(ADDR_SENDAREA_L, 8'hff); wr(ADDR_POS, 8'h03);
        i_core.run_block(BATC_XM_512);
        #1 chk("remaining", 24'hff, remaining_blocks);
        chk("send_area", 24'h100, 24'(send_area));
        chk("pos_512", 24'h0, 24'(first_block_position));
        wr(ADDR_POS, 8'h02);
        i_core.run_block(BATC_XM_1024);
        #1 chk("pos_1024", 24'h3, 24'(first_block_position));
        rd(ADDR_REMBLK_L); chk("remaining_rd", 24'hfe, 24'(d));
        fork
            wr(ADDR_REMBLK_L, 8'h40);
            i_core.run_block(BATC_XM_OTHER);
        join
        chk("write_wins", 24'h40, remaining_blocks);
        chk("pos_other", 24'h3, 24'(first_block_position));
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        s_regs();
        s_area();
        s_target();
        s_blocks();
        conclude();
    end
endmodule
